// file: hdl/fill_seq_pkg.sv
package fill_seq_pkg;
    // symbol counts of the closing states
    localparam logic [11:0] FILL_MIN = 12'h0080;  // least fill length, symbols
    localparam logic [11:0] FILL_MAX = 12'h0800;  // longest fill length, symbols
    localparam logic [3:0] MARK_LEN = 4'h0a;      // marker state length, symbols
    localparam logic [11:0] FILL_TARGET_RST = 12'h0080; // default planned fill length

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,   // before the fill state
        ST_FILL = 3'b001,   // remote final fill state
        ST_MARK = 3'b010,   // remote final marker state
        ST_DATA = 3'b011    // data mode
    } seq_state_t;

    // symbol kinds sent on the line
    typedef enum logic [1:0] {
        SYM_NONE = 2'b00,
        SYM_FILL = 2'b01,
        SYM_MARK = 2'b10,
        SYM_DATA = 2'b11
    } sym_kind_t;
endpackage : fill_seq_pkg

// file: hdl/fill_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - fill length follows central unit's entry
// - accept entering fill before or after central
// - early entry: fill until central enters
// - early: leave 128..2048 symbols after central
// - late entry: send 128..2048 fill symbols
// - fill leads to marker; edge marks timing
// - marker sends exactly ten marker symbols
// - after marker, enter data mode
// - four variants of parameter states supported
// - marker symbol is phase inverted fill
// - remote parameters lead straight to fill
module fill_sequencer
    import fill_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // symbol timing from the modulator, one pulse per symbol period
    input wire logic sym_tick,
    // entry requests from earlier states (parameter message or filler end)
    input wire logic start_fill,
    // central unit seen entering its final fill state (line pin level)
    input wire logic central_fill_seen,
    // planned fill length counted from central entry, or from own entry when late, clamped to limits
    input wire logic [11:0] fill_target,
    // line symbol outputs
    output var sym_kind_t sym_kind,
    output logic sym_phase_inv,
    // status
    output logic in_fill,
    output logic in_mark,
    output logic data_mode,
    output logic mark_start
);
    // central detect comes from the receiver path, treat as asynchronous
    logic cfs_meta;  // first stage, read only by second
    logic cfs_sync;
    logic central_in;  // latched: central has entered
    seq_state_t state;
    logic [3:0] mark_cnt;
    logic [11:0] since_central;
    logic [11:0] own_fill;
    logic [11:0] goal;
    logic entered_early;  // fill was entered before central was seen

    // two flop synchroniser
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfs_meta <= 1'b0;
            cfs_sync <= 1'b0;
        end else begin
            cfs_meta <= central_fill_seen;
            cfs_sync <= cfs_meta;
        end
    end

    // remember central entry; it never leaves again before data mode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            central_in <= 1'b0;
        end else if (cfs_sync) begin
            central_in <= 1'b1;
        end
    end

    // note which side entered first; only the early case is bounded by the
    // count from central entry, the late case is bounded by our own count
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            entered_early <= 1'b0;
        end else if (state == ST_IDLE && start_fill) begin
            entered_early <= !central_in;
        end
    end

    // symbols since central entered its fill state
    sym_counter u_central_cnt (
        .mclk(mclk),
        .rst_b(rst_b),
        .clear(1'b0),
        .run(central_in),
        .sym_tick(sym_tick),
        .count(since_central)
    );

    // fill symbols we sent ourselves
    sym_counter u_own_cnt (
        .mclk(mclk),
        .rst_b(rst_b),
        .clear(state != ST_FILL),
        .run(1'b1),
        .sym_tick(sym_tick),
        .count(own_fill)
    );

    // clamp the requested length into the legal window
    always_comb begin
        if (fill_target < FILL_MIN) begin
            goal = FILL_MIN;
        end else if (fill_target > FILL_MAX) begin
            goal = FILL_MAX;
        end else begin
            goal = fill_target;
        end
    end

    // main sequence
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            mark_cnt <= 4'h0;
            mark_start <= 1'b0;
        end else begin
            mark_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // entry is taken whether central is in or not
                    if (start_fill) begin
                        state <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    // both counts must reach the goal: early entry waits on central, late on own
                    if (sym_tick && central_in && since_central >= goal - 12'h001
                        && own_fill >= goal - 12'h001) begin
                        state <= ST_MARK;
                        mark_cnt <= 4'h0;
                        mark_start <= 1'b1;
                    end
                end
                ST_MARK: begin
                    if (sym_tick) begin
                        if (mark_cnt == MARK_LEN - 4'h1) begin
                            state <= ST_DATA;
                        end else begin
                            mark_cnt <= mark_cnt + 4'h1;
                        end
                    end
                end
                ST_DATA: begin
                    state <= ST_DATA;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // registered outputs follow the state
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sym_kind <= SYM_NONE;
            sym_phase_inv <= 1'b0;
            in_fill <= 1'b0;
            in_mark <= 1'b0;
            data_mode <= 1'b0;
        end else begin
            in_fill <= (state == ST_FILL);
            in_mark <= (state == ST_MARK);
            data_mode <= (state == ST_DATA);
            sym_phase_inv <= (state == ST_MARK);
            case (state)
                ST_FILL: sym_kind <= SYM_FILL;
                ST_MARK: sym_kind <= SYM_MARK;
                ST_DATA: sym_kind <= SYM_DATA;
                default: sym_kind <= SYM_NONE;
            endcase
        end
    end

    // checks
    sequence s_mark_run;
        in_mark [*2];
    endsequence

    // fill exit condition, both counts at the clamped goal
    sequence s_fill_exit;
        state == ST_FILL && sym_tick && central_in
            && since_central >= goal - 12'h001 && own_fill >= goal - 12'h001;
    endsequence

    // marker state entered together with its single start pulse
    sequence s_mark_entered;
        state == ST_MARK && mark_start;
    endsequence

    a_fill_not_short: assert property (@(posedge mclk) disable iff (!rst_b)
        (state == ST_FILL && $past(state) == ST_FILL && !central_in) |=> state != ST_MARK)
        else $error("left fill before central entry");
    a_fill_min_len: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(mark_start) |-> since_central >= FILL_MIN - 12'h001)
        else $error("fill shorter than minimum after central");
    a_fill_max_len: assert property (@(posedge mclk) disable iff (!rst_b)
        (state == ST_FILL && entered_early) |-> since_central <= FILL_MAX)
        else $error("fill longer than maximum after central");
    // late entry is bounded by the own fill count instead
    a_late_own_max: assert property (@(posedge mclk) disable iff (!rst_b)
        (state == ST_FILL && !entered_early) |-> own_fill <= FILL_MAX)
        else $error("too many own fill symbols");
    // the exit condition moves straight into the marker state
    a_fill_exit_mark: assert property (@(posedge mclk) disable iff (!rst_b)
        s_fill_exit |=> s_mark_entered)
        else $error("fill exit did not start marker");
    // data mode is kept until reset
    a_data_holds: assert property (@(posedge mclk) disable iff (!rst_b)
        data_mode |=> (data_mode && sym_kind == SYM_DATA))
        else $error("data mode left");
    a_own_min: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(mark_start) |-> own_fill >= FILL_MIN - 12'h001)
        else $error("too few own fill symbols");
    a_marker_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        mark_start |=> s_mark_run)
        else $error("marker state did not follow fill");
    a_marker_len: assert property (@(posedge mclk) disable iff (!rst_b)
        (state == ST_MARK && mark_cnt == MARK_LEN - 4'h1 && sym_tick) |=> state == ST_DATA)
        else $error("marker length wrong");
    a_marker_phase: assert property (@(posedge mclk) disable iff (!rst_b)
        (sym_kind == SYM_MARK) |-> sym_phase_inv)
        else $error("marker not phase inverted");
    a_entry_taken: assert property (@(posedge mclk) disable iff (!rst_b)
        (state == ST_IDLE && start_fill) |=> state == ST_FILL)
        else $error("fill entry refused");
endmodule : fill_sequencer
`default_nettype wire

// file: hdl/sym_counter.sv
`timescale 1ns/1ps
`default_nettype none
// counts symbol periods while run is high since the last clear, saturating at the top
module sym_counter
    import fill_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // control
    input wire logic clear,
    input wire logic run,
    input wire logic sym_tick,
    // count
    output logic [11:0] count
);
    // saturate so a late stop never wraps back under the minimum
    always_ff @(posedge mclk) begin
        if (!rst_b || clear) begin
            count <= 12'h0000;
        end else if (run && sym_tick && count != 12'hfff) begin
            count <= count + 12'h001;
        end
    end
endmodule : sym_counter
`default_nettype wire

// file: test/central_model.sv
`timescale 1ns/1ps
`default_nettype none
// central unit stand-in: raises its fill-entry level after a set symbol delay
module central_model
    import fill_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // symbol timing and launch
    input wire logic sym_tick,
    input wire logic go,
    input wire logic [11:0] delay,
    // line level seen by the remote unit
    output logic central_fill_seen,
    // central unit finished its marker state and is in data mode
    output logic central_data
);
    logic [11:0] wait_cnt; // symbols passed since launch
    logic [11:0] sent_cnt; // fill then marker symbols sent by the central unit
    // the level is sticky: the central unit never leaves fill backwards
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wait_cnt <= 12'h0000;
            central_fill_seen <= 1'b0;
        end else if (go && !central_fill_seen) begin
            if (wait_cnt == delay) central_fill_seen <= 1'b1;
            else if (sym_tick) wait_cnt <= wait_cnt + 12'h0001;
        end
    end
    // shortest legal central fill, then the fixed ten marker symbols
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sent_cnt <= 12'h0000;
            central_data <= 1'b0;
        end else if (central_fill_seen && !central_data && sym_tick) begin
            if (sent_cnt == FILL_MIN + {8'h00, MARK_LEN} - 12'h0001) begin
                central_data <= 1'b1;
            end else begin
                sent_cnt <= sent_cnt + 12'h0001;
            end
        end
    end
endmodule : central_model
`default_nettype wire

// file: test/dsl_init_final_fill_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_init_final_fill_sequencer_test;
    import fill_seq_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic sym_tick = 1'b0;
    logic start_fill = 1'b0;
    logic go = 1'b0;
    logic [11:0] delay = 12'h0000;
    logic [11:0] fill_target = 12'h0000;
    logic central_fill_seen, sym_phase_inv, in_fill, in_mark, data_mode, mark_start, central_data;
    sym_kind_t sym_kind;
    int err_total = 0;
    int checks_done = 0;
    int n_fill, n_mark, n_central, n_start, n_in_mark; // symbol and pulse tallies per run
    logic [31:0] lfsr = 32'hb2c8_43d1; // fixed seed keeps runs repeatable
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // planned length after clamping to the legal fill span
    function automatic int clamp_goal(input logic [11:0] t);
        return (t < FILL_MIN) ? FILL_MIN : ((t > FILL_MAX) ? FILL_MAX : t);
    endfunction : clamp_goal
    task automatic check_bit(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit
    task automatic check_range(input string what, input int lo, input int hi, input int seen);
        checks_done++;
        if (seen < lo || seen > hi) begin
            err_total++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask : check_range
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    fill_sequencer i_dut (.mclk(mclk), .rst_b(rst_b), .sym_tick(sym_tick), .start_fill(start_fill),
        .central_fill_seen(central_fill_seen), .fill_target(fill_target), .sym_kind(sym_kind),
        .sym_phase_inv(sym_phase_inv), .in_fill(in_fill), .in_mark(in_mark), .data_mode(data_mode),
        .mark_start(mark_start));
    central_model i_central (.mclk(mclk), .rst_b(rst_b), .sym_tick(sym_tick), .go(go),
        .delay(delay), .central_fill_seen(central_fill_seen), .central_data(central_data));
    initial forever #2.5 mclk = ~mclk;
    // sample settled outputs first, then toggle the symbol tick (one symbol every two cycles)
    always @(negedge mclk) begin
        if (!rst_b) begin
            n_fill = 0;
            n_mark = 0;
            n_central = 0;
            n_start = 0;
            n_in_mark = 0;
        end else begin
            check_bit("phase_inv", sym_kind === SYM_MARK, sym_phase_inv);
            n_start += (mark_start === 1'b1);
            if (sym_tick && sym_kind === SYM_FILL) n_fill++;
            if (sym_tick && sym_kind === SYM_FILL && central_fill_seen) n_central++;
            if (sym_tick && sym_kind === SYM_MARK) n_mark++;
            if (sym_tick && in_mark === 1'b1) n_in_mark++;
        end
        sym_tick <= ~sym_tick;
    end
    // one run from reset; early means the remote unit enters fill before the central unit
    task automatic run_case(input logic early, input logic [11:0] target);
        int goal;
        int k;
        goal = clamp_goal(target);
        @(negedge mclk);
        rst_b = 1'b0; go = 1'b0; start_fill = 1'b0; fill_target = target;
        delay = early ? 12'h0040 : 12'h0000;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1; go = 1'b1;
        if (!early) repeat (20) @(negedge mclk);
        start_fill = 1'b1;
        repeat (3) @(negedge mclk);
        start_fill = 1'b0;
        check_bit("in_fill", 1'b1, in_fill);
        for (k = 0; k < 12000 && data_mode !== 1'b1; k++) @(negedge mclk);
        start_fill = 1'b1; // ignored outside idle
        repeat (4) @(negedge mclk);
        check_bit("data_mode", 1'b1, data_mode);
        check_bit("kind_data", 1'b1, sym_kind === SYM_DATA);
        check_range("mark_syms", 10, 10, n_mark);
        check_range("in_mark_syms", 10, 10, n_in_mark);
        check_bit("in_fill_end", 1'b0, in_fill);
        check_bit("central_data", 1'b1, central_data);
        check_range("mark_pulses", 1, 1, n_start);
        if (early) begin
            check_range("since_central", goal - 3, goal + 3, n_central);
            check_range("fill_total", n_central + 32, 4200, n_fill);
        end else begin
            check_range("fill_syms", goal - 3, goal + 3, n_fill);
        end
        $display("test done early %0d goal %0d fill %0d", early, goal, n_fill);
    endtask : run_case
    initial begin
        #(5.0 * 60000);
        err_total++;
        complete_run();
    end
    initial begin
        run_case(1'b1, 12'h0000);
        run_case(1'b0, 12'h0fff);
        run_case(1'b1, FILL_MAX);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            run_case(i[0], FILL_MIN + {3'h0, lfsr[8:0]});
        end
        complete_run();
    end
endmodule : dsl_init_final_fill_sequencer_test
`default_nettype wire
